/* File: tqsel_ctrl_model.sv */
// ============================================================================
// external motion controller: drives select pins, servo on and analog input
// ============================================================================
module tqsel_ctrl_model (
  input  wire logic        aclk,             // shared clock
  output logic             torque_sel_bit0,  // select pin 0
  output logic             torque_sel_bit1,  // select pin 1
  output logic             servo_on,         // servo on pin
  output logic [15:0]      analog_mv         // analog input in mV
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    torque_sel_bit0 = 1'b0;
    torque_sel_bit1 = 1'b0;
    servo_on        = 1'b0;
    analog_mv       = 16'h0000;
  end

  // lag gives extra idle edges so that slow controllers are mimicked
  task automatic power(input logic on, input int lag);
    repeat (lag + 1) @(posedge aclk);
    servo_on <= on;
  endtask

  task automatic pick(input logic [1:0] code, input int lag);
    repeat (lag + 1) @(posedge aclk);
    if (servo_on) begin  // selection made only once switched on
      torque_sel_bit1 <= code[1];
      torque_sel_bit0 <= code[0];
    end
  endtask

  task automatic volts(input logic signed [15:0] v);
    @(posedge aclk);
    analog_mv <= (v > 16'sh2710) ? 16'h2710 : (v < -16'sh2710) ? 16'hd8f0 : v;
  endtask
endmodule

/* File: tqsel_pkg.sv */
package tqsel_pkg;

  // ==========================================================================
  // register map: printed offsets are word indices, byte address is four times
  // ==========================================================================
  localparam int unsigned TQSEL_ADDR_W        = 12;
  localparam logic [11:0] TQSEL_IDX_SMOOTH    = 12'h10e;
  localparam logic [11:0] TQSEL_IDX_FULLSCALE = 12'h152;
  localparam logic [11:0] TQSEL_IDX_PRESET1   = 12'h200;
  localparam logic [11:0] TQSEL_IDX_PRESET2   = 12'h201;
  localparam logic [11:0] TQSEL_IDX_PRESET3   = 12'h202;
  localparam logic [11:0] TQSEL_IDX_CTRL      = 12'h203;
  localparam logic [11:0] TQSEL_IDX_STATUS    = 12'h204;

  // ==========================================================================
  // reset values and ranges
  // ==========================================================================
  localparam logic [15:0] TQSEL_SMOOTH_RST    = 16'h0000;
  localparam logic [15:0] TQSEL_FULLSCALE_RST = 16'h0064;
  localparam logic [15:0] TQSEL_PRESET_RST    = 16'h0000;
  localparam logic [1:0]  TQSEL_CTRL_RST      = 2'h0;
  localparam logic [15:0] TQSEL_SMOOTH_MAX    = 16'h03e8;
  localparam logic [15:0] TQSEL_FULLSCALE_MAX = 16'h03e8;
  localparam logic [15:0] TQSEL_PRESET_MAX    = 16'h012c;
  localparam logic [15:0] TQSEL_PRESET_MIN    = 16'hfed4;

  // ==========================================================================
  // control and status fields
  // ==========================================================================
  localparam int unsigned TQSEL_CTRL_ZERO_BIT = 0;
  localparam int unsigned TQSEL_CTRL_LIM_BIT  = 1;
  localparam int unsigned TQSEL_STAT_SEL_LSB  = 16;
  localparam int unsigned TQSEL_STAT_ON_BIT   = 18;

  // ==========================================================================
  // scaling and timing
  // ==========================================================================
  localparam int unsigned TQSEL_MV_PER_V      = 1000;
  localparam int unsigned TQSEL_FS_REF_V      = 10;
  localparam int unsigned TQSEL_SCALE_DIV     = TQSEL_MV_PER_V * TQSEL_FS_REF_V;
  localparam int unsigned TQSEL_CLK_PERIOD_NS = 50;
  localparam int unsigned TQSEL_SAMPLE_MS     = 1;
  localparam int unsigned TQSEL_TICK_CYCLES   =
    (TQSEL_SAMPLE_MS * 1000000) / TQSEL_CLK_PERIOD_NS;
  localparam int unsigned TQSEL_FRAC_W        = 16;

  localparam logic [1:0] TQSEL_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TQSEL_RESP_DECERR = 2'h3;

endpackage

/* File: tqsel_top.sv */
// Operation
// - zero-variant mode with select 00 gives zero, torque mode only
// - analog mode select 00 takes analog input
// - codes 01/10/11 pick presets, range +-300%
// - new preset applied once select bit changes
// - position/speed modes use selection as limit
// - low-pass filter, constant 0..1000 ms, default 0
// - constant zero bypasses the filter
// - analog percent is volts times scale over 10
// - full scale 0..1000, default 100, torque mode
// - full scale sets limit at 10 V in limit mode
// - selection acted on only after servo on
//
// Chosen here: the AXI4-Lite register port.
module tqsel_top
  import tqsel_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TQSEL_TICK_CYCLES
) (
  input  wire logic        aclk,             // 20 MHz clock
  input  wire logic        aresetn,          // synchronous reset, low active
  input  wire logic [11:0] s_axi_awaddr,     // write address
  input  wire logic        s_axi_awvalid,    // write address valid
  output logic             s_axi_awready,    // write address ready
  input  wire logic [31:0] s_axi_wdata,      // write data
  input  wire logic [3:0]  s_axi_wstrb,      // write byte strobes
  input  wire logic        s_axi_wvalid,     // write data valid
  output logic             s_axi_wready,     // write data ready
  output logic [1:0]       s_axi_bresp,      // write response
  output logic             s_axi_bvalid,     // write response valid
  input  wire logic        s_axi_bready,     // write response ready
  input  wire logic [11:0] s_axi_araddr,     // read address
  input  wire logic        s_axi_arvalid,    // read address valid
  output logic             s_axi_arready,    // read address ready
  output logic [31:0]      s_axi_rdata,      // read data
  output logic [1:0]       s_axi_rresp,      // read response
  output logic             s_axi_rvalid,     // read data valid
  input  wire logic        s_axi_rready,     // read data ready
  input  wire logic        torque_sel_bit0,  // select pin 0, async
  input  wire logic        torque_sel_bit1,  // select pin 1, async
  input  wire logic        servo_on,         // servo on pin, async
  input  wire logic [15:0] analog_mv,        // signed analog input in mV
  output logic [15:0]      torque_cmd,       // signed torque command, %
  output logic [15:0]      torque_limit      // signed torque limit, %
);

  if (TICK_CYCLES < 2) begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end

  localparam int unsigned CNT_W = $clog2(TICK_CYCLES);

  // ==========================================================================
  // pin synchronisers and select tracking
  // ==========================================================================
  logic [2:0]  pin_in;
  logic [2:0]  sy0_r, sy1_r, sy2_r;
  logic [2:0]  stb_r, stb_nxt;
  logic [1:0]  sel_code;
  logic        on_stb;
  logic        sel_chg, on_rise;

  assign pin_in   = {servo_on, torque_sel_bit1, torque_sel_bit0};
  assign sel_code = stb_r[1:0];
  assign on_stb   = stb_r[2];

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      stb_nxt[i] = (sy1_r[i] == sy2_r[i]) ? sy2_r[i] : stb_r[i];
    end
  end

  assign sel_chg = (stb_nxt[1:0] != stb_r[1:0]);
  assign on_rise = stb_nxt[2] & ~stb_r[2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy0_r <= 3'h0;
      sy1_r <= 3'h0;
      sy2_r <= 3'h0;
      stb_r <= 3'h0;
    end else begin
      sy0_r <= pin_in;
      sy1_r <= sy0_r;
      sy2_r <= sy1_r;
      stb_r <= stb_nxt;
    end
  end

  // ==========================================================================
  // register file and AXI4-Lite slave
  // ==========================================================================
  logic [15:0] smooth_r, smooth_nxt;
  logic [15:0] fs_r, fs_nxt;
  logic [15:0] pre_r [3];
  logic [15:0] pre_nxt [3];
  logic [1:0]  ctrl_r, ctrl_nxt;
  logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [11:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        awready_r, awready_nxt, wready_r, wready_nxt;
  logic        bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [15:0] filt_out;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [15:0] clamp_u(input logic [15:0] v, input logic [15:0] mx);
    clamp_u = (v > mx) ? mx : v;
  endfunction

  function automatic logic [15:0] clamp_s(input logic [15:0] v);
    if ($signed(v) > $signed(TQSEL_PRESET_MAX)) clamp_s = TQSEL_PRESET_MAX;
    else if ($signed(v) < $signed(TQSEL_PRESET_MIN)) clamp_s = TQSEL_PRESET_MIN;
    else clamp_s = v;
  endfunction

  always_comb begin
    logic        do_wr;
    logic [11:0] widx, ridx;
    logic [15:0] m;
    do_wr       = aw_hold_r & w_hold_r & ~bvalid_r;
    widx        = {2'h0, awaddr_r[11:2]};
    ridx        = {2'h0, s_axi_araddr[11:2]};
    m           = merge16(16'h0000, wdata_r, wstrb_r);
    smooth_nxt  = smooth_r;
    fs_nxt      = fs_r;
    pre_nxt     = pre_r;
    ctrl_nxt    = ctrl_r;
    aw_hold_nxt = aw_hold_r | (s_axi_awvalid & awready_r);
    w_hold_nxt  = w_hold_r | (s_axi_wvalid & wready_r);
    awaddr_nxt  = (s_axi_awvalid & awready_r) ? s_axi_awaddr : awaddr_r;
    wdata_nxt   = (s_axi_wvalid & wready_r) ? s_axi_wdata : wdata_r;
    wstrb_nxt   = (s_axi_wvalid & wready_r) ? s_axi_wstrb : wstrb_r;
    bvalid_nxt  = bvalid_r & ~s_axi_bready;
    bresp_nxt   = bresp_r;
    if (do_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = TQSEL_RESP_OKAY;
      unique case (widx)
        TQSEL_IDX_SMOOTH: begin
          smooth_nxt = clamp_u(merge16(smooth_r, wdata_r, wstrb_r), TQSEL_SMOOTH_MAX);
        end
        TQSEL_IDX_FULLSCALE: begin
          fs_nxt = clamp_u(merge16(fs_r, wdata_r, wstrb_r), TQSEL_FULLSCALE_MAX);
        end
        TQSEL_IDX_PRESET1: pre_nxt[0] = clamp_s(merge16(pre_r[0], wdata_r, wstrb_r));
        TQSEL_IDX_PRESET2: pre_nxt[1] = clamp_s(merge16(pre_r[1], wdata_r, wstrb_r));
        TQSEL_IDX_PRESET3: pre_nxt[2] = clamp_s(merge16(pre_r[2], wdata_r, wstrb_r));
        TQSEL_IDX_CTRL: begin
          if (wstrb_r[0]) ctrl_nxt = m[1:0];
        end
        TQSEL_IDX_STATUS: bresp_nxt = TQSEL_RESP_OKAY;
        default: bresp_nxt = TQSEL_RESP_DECERR;
      endcase
    end
    awready_nxt = ~aw_hold_nxt & ~bvalid_nxt;
    wready_nxt  = ~w_hold_nxt & ~bvalid_nxt;
    // read side: one outstanding read
    rvalid_nxt  = rvalid_r & ~s_axi_rready;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (s_axi_arvalid & arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = TQSEL_RESP_OKAY;
      unique case (ridx)
        TQSEL_IDX_SMOOTH:    rdata_nxt = {16'h0000, smooth_r};
        TQSEL_IDX_FULLSCALE: rdata_nxt = {16'h0000, fs_r};
        TQSEL_IDX_PRESET1:   rdata_nxt = {16'h0000, pre_r[0]};
        TQSEL_IDX_PRESET2:   rdata_nxt = {16'h0000, pre_r[1]};
        TQSEL_IDX_PRESET3:   rdata_nxt = {16'h0000, pre_r[2]};
        TQSEL_IDX_CTRL:      rdata_nxt = {30'h00000000, ctrl_r};
        TQSEL_IDX_STATUS:    rdata_nxt = {13'h0000, on_stb, sel_code, filt_out};
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = TQSEL_RESP_DECERR;
        end
      endcase
    end
    arready_nxt = ~rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smooth_r  <= TQSEL_SMOOTH_RST;
      fs_r      <= TQSEL_FULLSCALE_RST;
      pre_r     <= '{default: TQSEL_PRESET_RST};
      ctrl_r    <= TQSEL_CTRL_RST;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 12'h000;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= TQSEL_RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= TQSEL_RESP_OKAY;
    end else begin
      smooth_r  <= smooth_nxt;
      fs_r      <= fs_nxt;
      pre_r     <= pre_nxt;
      ctrl_r    <= ctrl_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // ==========================================================================
  // command source selection and analog scaling
  // ==========================================================================
  logic signed [32:0] ana_prod;
  logic        [15:0] ana_pct;
  logic        [15:0] hold_r, hold_nxt, sel_cmd_r, sel_cmd_nxt;

  assign ana_prod = $signed(analog_mv) * $signed({1'b0, fs_r});
  assign ana_pct  = 16'(ana_prod / $signed(33'(TQSEL_SCALE_DIV)));

  always_comb begin
    hold_nxt = hold_r;
    if ((sel_chg | on_rise) && stb_nxt[1:0] != 2'h0) begin
      hold_nxt = pre_r[stb_nxt[1:0] - 2'h1];
    end
    if (!on_stb) begin
      sel_cmd_nxt = 16'h0000;
    end else if (sel_code != 2'h0) begin
      sel_cmd_nxt = hold_r;
    end else if (ctrl_r[TQSEL_CTRL_ZERO_BIT] && !ctrl_r[TQSEL_CTRL_LIM_BIT]) begin
      sel_cmd_nxt = 16'h0000;
    end else begin
      sel_cmd_nxt = ana_pct;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_r    <= 16'h0000;
      sel_cmd_r <= 16'h0000;
    end else begin
      hold_r    <= hold_nxt;
      sel_cmd_r <= sel_cmd_nxt;
    end
  end

  // ==========================================================================
  // smoothing filter and outputs
  // ==========================================================================
  logic [CNT_W-1:0]   tick_cnt_r, tick_cnt_nxt;
  logic               tick;
  logic signed [31:0] acc_r, acc_nxt;
  logic [15:0]        cmd_r, cmd_nxt, lim_r, lim_nxt;

  assign tick     = (tick_cnt_r == CNT_W'(TICK_CYCLES - 1));
  assign filt_out = acc_r[31:TQSEL_FRAC_W];

  always_comb begin
    logic signed [32:0] diff;
    logic signed [32:0] step;
    diff         = $signed({sel_cmd_r[15], sel_cmd_r, 16'h0000}) - 33'(acc_r);
    step         = diff / $signed({17'h00000, smooth_r} + 33'sh1);
    tick_cnt_nxt = tick ? '0 : tick_cnt_r + CNT_W'(1);
    acc_nxt      = acc_r;
    if (smooth_r == 16'h0000) begin
      acc_nxt = $signed({sel_cmd_r, 16'h0000});
    end else if (tick) begin
      acc_nxt = acc_r + step[31:0];
    end
    if (ctrl_r[TQSEL_CTRL_LIM_BIT]) begin
      cmd_nxt = 16'h0000;
      lim_nxt = filt_out;
    end else begin
      cmd_nxt = filt_out;
      lim_nxt = 16'h0000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_r <= '0;
      acc_r      <= 32'sh0;
      cmd_r      <= 16'h0000;
      lim_r      <= 16'h0000;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      acc_r      <= acc_nxt;
      cmd_r      <= cmd_nxt;
      lim_r      <= lim_nxt;
    end
  end

  assign torque_cmd   = cmd_r;
  assign torque_limit = lim_r;

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_new_sel;
    sel_chg && stb_nxt[1:0] != 2'h0;
  endsequence
  sequence s_preset_used;
    ##1 (on_stb && sel_code != 2'h0) ##1 sel_cmd_r == $past(hold_r);
  endsequence

  AST_ZERO_VARIANT: assert property (on_stb && sel_code == 2'h0 && ctrl_r == 2'h1
    |=> sel_cmd_r == 16'h0000) else $error("zero variant did not give zero");
  AST_ANALOG_PATH: assert property (on_stb && sel_code == 2'h0 && ctrl_r == 2'h0
    |=> sel_cmd_r == $past(ana_pct)) else $error("analog command not taken");
  AST_PRESET_PICK: assert property (s_new_sel
    |=> hold_r == $past(pre_r[stb_nxt[1:0] - 2'h1])) else $error("wrong preset");
  AST_PRESET_APPLY: assert property ((s_new_sel and (stb_nxt[2] && stb_r[2]))
    |-> s_preset_used) else $error("new preset not applied");
  AST_LIMIT_MODE: assert property (ctrl_r[TQSEL_CTRL_LIM_BIT]
    |=> torque_cmd == 16'h0000 && torque_limit == $past(filt_out))
    else $error("limit routing wrong");
  AST_SMOOTH_RANGE: assert property (smooth_r <= TQSEL_SMOOTH_MAX)
    else $error("smoothing constant out of range");
  AST_BYPASS: assert property (smooth_r == 16'h0000 && $stable(smooth_r)
    |=> filt_out == $past(sel_cmd_r)) else $error("bypass not transparent");
  AST_SCALE: assert property (on_stb && sel_code == 2'h0 && !ctrl_r[0]
    |=> $signed(sel_cmd_r) == $signed($past(ana_prod) / 33'sd10000))
    else $error("analog scaling wrong");
  AST_FS_RANGE: assert property (fs_r <= TQSEL_FULLSCALE_MAX)
    else $error("full scale out of range");
  AST_SERVO_OFF: assert property (!on_stb |=> sel_cmd_r == 16'h0000)
    else $error("command while servo off");
  AST_FILTER_HOLD: assert property (smooth_r != 16'h0000 && !tick
    |=> acc_r == $past(acc_r)) else $error("filter moved between samples");

endmodule

/* File: tqsel_top_tb.sv */
module tqsel_top_tb;
  import tqsel_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // signals
  // ==========================================================================
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, rdt;
  logic        sel0, sel1, son;
  logic [15:0] mv, tcmd, tlim;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cyc = 0;

  always #25 aclk = ~aclk;

  tqsel_top #(.TICK_CYCLES(20)) uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .torque_sel_bit0(sel0), .torque_sel_bit1(sel1), .servo_on(son),
    .analog_mv(mv), .torque_cmd(tcmd), .torque_limit(tlim)
  );

  tqsel_ctrl_model ctl (
    .aclk(aclk), .torque_sel_bit0(sel0), .torque_sel_bit1(sel1),
    .servo_on(son), .analog_mv(mv)
  );

  // ==========================================================================
  // checking and closing
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d, failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_fail++;
      tally_and_finish;
    end
  end

  // ==========================================================================
  // register bus master
  // ==========================================================================
  task automatic axw(input logic [11:0] a, input logic [15:0] v, input logic [3:0] st,
                     output logic [1:0] rs);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {16'h0000, v};
    wstrb   <= st;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      awvalid <= awvalid & ~awready;
      wvalid  <= wvalid & ~wready;
      if (bvalid && bready) begin
        rs = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] dt, output logic [1:0] rs);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      arvalid <= arvalid & ~arready;
      if (rvalid && rready) begin
        dt = rdata;
        rs = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic wr(input logic [11:0] idx, input logic [15:0] v);
    logic [1:0] rs;
    axw({idx[9:0], 2'b00}, v, 4'hf, rs);
  endtask

  task automatic rc(input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] dt;
    logic [1:0]  rs;
    axr({idx[9:0], 2'b00}, dt, rs);
    chk(dt, exp);
    chk(rs, TQSEL_RESP_OKAY);
  endtask

  // outputs settle a fixed few cycles after any pin or register change while the smoothing constant is zero
  task automatic sc(input logic [15:0] e_cmd, input logic [15:0] e_lim);
    repeat (12) @(posedge aclk);
    chk(tcmd, e_cmd);
    chk(tlim, e_lim);
  endtask

  // ==========================================================================
  // tests
  // ==========================================================================
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    sc(16'h0000, 16'h0000);
    rc(TQSEL_IDX_SMOOTH, 32'h0);
    rc(TQSEL_IDX_FULLSCALE, 32'h64);
    axr(12'h900, rdt, r);
    chk(rdt, 32'h0);
    chk(r, TQSEL_RESP_DECERR);
    axw(12'h904, 16'h0001, 4'hf, r);
    chk(r, TQSEL_RESP_DECERR);
    wr(TQSEL_IDX_PRESET1, 16'h0032);
    wr(TQSEL_IDX_PRESET2, 16'hff9c);
    wr(TQSEL_IDX_PRESET3, 16'h0190);
    wr(TQSEL_IDX_FULLSCALE, 16'h03e9);
    rc(TQSEL_IDX_PRESET3, 32'h12c);
    rc(TQSEL_IDX_PRESET2, 32'hff9c);
    rc(TQSEL_IDX_FULLSCALE, 32'h3e8);
    axw({TQSEL_IDX_FULLSCALE[9:0], 2'b00}, 16'h0064, 4'h1, r);
    chk(r, TQSEL_RESP_OKAY);
    rc(TQSEL_IDX_FULLSCALE, 32'h364);
    wr(TQSEL_IDX_FULLSCALE, 16'h0064);
    ctl.power(1'b1, 0);
    ctl.volts(16'h1388);
    sc(16'h0032, 16'h0000);
    wr(TQSEL_IDX_FULLSCALE, 16'h00c8);
    ctl.volts(16'hf63c);
    sc(16'hffce, 16'h0000);
    wr(TQSEL_IDX_CTRL, 16'h0001);
    sc(16'h0000, 16'h0000);
    ctl.pick(2'b01, 3);
    sc(16'h0032, 16'h0000);
    wr(TQSEL_IDX_PRESET1, 16'h004d);
    sc(16'h0032, 16'h0000);
    ctl.pick(2'b10, 0);
    sc(16'hff9c, 16'h0000);
    ctl.pick(2'b11, 0);
    sc(16'h012c, 16'h0000);
    rc(TQSEL_IDX_STATUS, 32'h0007012c);
    ctl.pick(2'b01, 0);
    sc(16'h004d, 16'h0000);
    wr(TQSEL_IDX_CTRL, 16'h0002);
    ctl.pick(2'b10, 0);
    sc(16'h0000, 16'hff9c);
    ctl.pick(2'b00, 0);
    ctl.volts(16'h2710);
    wr(TQSEL_IDX_FULLSCALE, 16'h00fa);
    sc(16'h0000, 16'h00fa);
    wr(TQSEL_IDX_CTRL, 16'h0003);
    sc(16'h0000, 16'h00fa);
    ctl.power(1'b0, 0);
    sc(16'h0000, 16'h0000);
    wr(TQSEL_IDX_CTRL, 16'h0000);
    wr(TQSEL_IDX_FULLSCALE, 16'h0064);
    ctl.volts(16'h0000);
    ctl.power(1'b1, 0);
    sc(16'h0000, 16'h0000);
    wr(TQSEL_IDX_SMOOTH, 16'h03e9);
    rc(TQSEL_IDX_SMOOTH, 32'h3e8);
    wr(TQSEL_IDX_SMOOTH, 16'h0002);
    ctl.volts(16'h2710);
    repeat (12) @(posedge aclk);
    chk(tcmd === 16'h0064, 1'b0);
    repeat (1200) @(posedge aclk);
    chk(tcmd > 16'h0061 && tcmd <= 16'h0064, 1'b1);
    wr(TQSEL_IDX_SMOOTH, 16'h0000);
    ctl.volts(16'h1388);
    sc(16'h0032, 16'h0000);
    tally_and_finish;
  end
endmodule
